// ==== crc_device_model.sv ====
// Behavioural model of the CRC generator as seen through its register port.
// Assumes one-cycle strobes from the host; reads answer in the next cycle.
`timescale 1ns/1ps
module crc_device_model #(
  parameter int INSTR_CLKS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input crc_host_pkg::devBus_t devBus,
  output logic [15:0] devRdata,
  output logic devIrq
);
  logic [15:0] con1_r, con2_r;
  logic [31:0] taps_r, dat_r, crc_r, shift_r;
  logic [31:0] q[$];
  int bitsLeft, wordW, tick, depth, w, pl;

  function automatic logic [31:0] stepBit(logic [31:0] c, logic d);
    logic fb;
    fb = c[pl] ^ d;
    return ((c << 1) ^ (fb ? (taps_r | 32'h1) : 32'h0)) & (32'hffff_ffff >> (31 - pl));
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      con1_r = '0;
      con2_r = '0;
      taps_r = '0;
      tick = 0;
      devRdata <= '0;
      devIrq <= 1'b0;
    end else begin
      w = con2_r[12:8];
      pl = con2_r[4:0];
      depth = w > 15 ? 4 : (w > 7 ? 8 : 16);
      devIrq <= 1'b0;
      // Idle bus inverts the read data every cycle, so it alternates between the last value and its inverse
      if (devBus.rd) begin
        case (devBus.addr)
          crc_host_pkg::DEV_CON1: devRdata <= {con1_r[15], 1'b0, con1_r[13], 5'(q.size()),
            q.size() == depth, q.size() == 0, con1_r[5:3], 3'h0};
          crc_host_pkg::DEV_CON2: devRdata <= con2_r;
          crc_host_pkg::DEV_TAPL: devRdata <= taps_r[15:0];
          crc_host_pkg::DEV_TAPH: devRdata <= taps_r[31:16];
          crc_host_pkg::DEV_RESL: devRdata <= crc_r[15:0];
          crc_host_pkg::DEV_RESH: devRdata <= crc_r[31:16];
          default: devRdata <= '0;
        endcase
      end else begin
        devRdata <= ~devRdata;
      end
      if (devBus.wr) begin
        case (devBus.addr)
          crc_host_pkg::DEV_CON1: con1_r = devBus.wdata & 16'ha038;
          crc_host_pkg::DEV_CON2: con2_r = devBus.wdata & 16'h1f1f;
          crc_host_pkg::DEV_TAPL: taps_r[15:0] = devBus.wdata & 16'hfffe;
          crc_host_pkg::DEV_TAPH: taps_r[31:16] = devBus.wdata;
          crc_host_pkg::DEV_DATL: dat_r[15:0] = devBus.wdata;
          crc_host_pkg::DEV_DATH: dat_r[31:16] = devBus.wdata;
          crc_host_pkg::DEV_RESL: crc_r[15:0] = devBus.wdata;
          default: crc_r[31:16] = devBus.wdata;
        endcase
        // A word is queued only when its top bit lands; excess words are lost
        if (q.size() < depth && ((devBus.addr == crc_host_pkg::DEV_DATL && w < 16) ||
            (devBus.addr == crc_host_pkg::DEV_DATH && w > 15))) q.push_back(dat_r);
      end
      if (!con1_r[15]) begin
        q.delete();
        bitsLeft = 0;
        crc_r = '0;
        dat_r = '0;
      end
      tick = (tick + 1) % INSTR_CLKS;
      if (con1_r[15] && con1_r[4] && tick == 0) begin
        if (bitsLeft == 0 && q.size() > 0) begin
          shift_r = q.pop_front();
          wordW = w;
          bitsLeft = w + 1;
        end else if (bitsLeft > 0) begin
          repeat (2) if (bitsLeft > 0) begin
            bitsLeft--;
            crc_r = stepBit(crc_r, con1_r[3] ? shift_r[wordW - bitsLeft] : shift_r[bitsLeft]);
          end
          if (bitsLeft == 0 && q.size() == 0) devIrq <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== crc_host.sv ====
// Host controller that drives a programmable CRC generator through its register port.
// Assumes the device answers a read one cycle later and raises devIrq for one cycle per interrupt.
//
// Notes on behaviour
// (RULE1) Enable bit is written first, before any other device register.
// (RULE2) Tap pair and polynomial length are programmed before starting.
// (RULE3) Word width and bit order are programmed before starting.
// (RULE4) Start bit written 1 to run the shifter, 0 to stop it.
// (RULE5) Seed is written into the result pair after starting.
// (RULE6) Words go to the data pair only while the full flag reads zero.
// (RULE7) Empty flag is awaited before the result is extracted.
// (RULE8) Wide words: wait (width+1)/2 instruction cycles after empty.
// (RULE9) Wide words: set width to polynomial length, write one dummy word.
// (RULE10) Device moves a word within two cycles, shifts in (length+1)/2 more.
// (RULE11) Narrow words: select shift-complete interrupt, clear flag, write dummy, wait.
// (RULE12) Result pair is read after final shifts; width is then restored.
// (RULE13) Width at most length: stop, clear flag, dummy data, restart, wait.
// (RULE14) Select 0 gives the interrupt only after all shifts complete.
// (RULE15) Data and result are each a pair of 16-bit registers.
// (RULE16) Device reports queued word count in a 5-bit field.
// (RULE17) FIFO depth is 4, 8 or 16 words depending on width.
// (RULE18) Bit-order select picks LSb first; result stays non-reflected.
// (RULE19) Engine shifts two bits per instruction cycle.
// (RULE20) Low data register is written before the high one.
// (RULE21) Clearing enable empties the device FIFO and resets its engine.
// (RULE22) Full when count equals depth, empty when count is zero.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module crc_host #(
  parameter int INSTR_CLKS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software register port
  input wire logic [3:0] swAddr,
  input wire logic [31:0] swWdata,
  input wire logic swWe,
  input wire logic swRe,
  output logic [31:0] swRdata,
  // Device register port
  output crc_host_pkg::devBus_t devBus,
  input wire logic [15:0] devRdata,
  input wire logic devIrq
);
  if (INSTR_CLKS < 1 || INSTR_CLKS > 255) begin
    $error("INSTR_CLKS out of range");
  end

  crc_host_pkg::state_t state_r;
  crc_host_pkg::devBus_t devBus_r;
  logic [31:0] cfg_r;
  logic [31:0] taps_r;
  logic [31:0] seed_r;
  logic [31:0] data_r;
  logic [31:0] result_r;
  logic pending_r;
  logic finishReq_r;
  logic done_r;
  logic irqFlag_r;
  logic chkEmpty_r;
  logic ansWait_r;
  logic [6:0] idx_r;
  logic [6:0] wait_r;
  crc_host_pkg::state_t waitNext_r;
  logic [7:0] div_r;
  logic tick;
  logic [4:0] width;
  logic [4:0] poly_length_field;
  logic lsbFirst;
  logic [6:0] dummyWords;
  logic startCmd;
  logic finishCmd;
  logic abortCmd;
  logic dataWr;
  logic consume;
  logic irqClear;

  assign width = cfg_r[crc_host_pkg::CFG_WIDTH_LO +: 5];
  assign poly_length_field = cfg_r[4:0];
  assign lsbFirst = cfg_r[crc_host_pkg::CFG_LSBFIRST];
  // Words needed so that the dummy data covers at least the polynomial length
  assign dummyWords = 7'((7'(poly_length_field) + 7'(width) + 7'h01) / (7'(width) + 7'h01));
  assign startCmd = swWe && swAddr == crc_host_pkg::H_CMD && swWdata[crc_host_pkg::CMD_START];
  assign finishCmd = swWe && swAddr == crc_host_pkg::H_CMD && swWdata[crc_host_pkg::CMD_FINISH];
  assign abortCmd = swWe && swAddr == crc_host_pkg::H_CMD && swWdata[crc_host_pkg::CMD_ABORT];
  assign dataWr = swWe && swAddr == crc_host_pkg::H_DATA;
  assign consume = state_r == crc_host_pkg::S_FEEDH;
  // Cleared once the stop write has landed, so a late interrupt of the last word is not kept
  assign irqClear = state_r == crc_host_pkg::S_FLUSH && idx_r == 7'h02;
  assign devBus = devBus_r;

  function automatic logic [15:0] con1Word(input logic go, input logic lsb);
    logic [15:0] w;
    w = 16'h0000;
    w[crc_host_pkg::CON1_ENABLE] = 1'b1;
    w[crc_host_pkg::CON1_IRQSEL] = 1'b0; // RULE11 RULE14
    w[crc_host_pkg::CON1_GO] = go; // RULE4
    w[crc_host_pkg::CON1_LSBFIRST] = lsb; // RULE18
    return w;
  endfunction

  function automatic logic [15:0] con2Word(input logic [4:0] wd, input logic [4:0] pl);
    logic [15:0] w;
    w = 16'h0000;
    w[crc_host_pkg::CON2_WIDTH_LO +: 5] = wd;
    w[crc_host_pkg::CON2_POLY_LENGTH_FIELD_LO +: 5] = pl;
    return w;
  endfunction

  // Instruction-cycle enable; device waits are counted in these ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
    end else if (div_r == 8'(INSTR_CLKS - 1)) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign tick = div_r == 8'(INSTR_CLKS - 1);

  // Software-owned configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= 32'h0000_0000;
      taps_r <= 32'h0000_0000;
      seed_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
    end else if (swWe) begin
      case (swAddr)
        crc_host_pkg::H_CFG: cfg_r <= swWdata & 32'h0001_1f1f;
        crc_host_pkg::H_TAPS: taps_r <= swWdata;
        crc_host_pkg::H_SEED: seed_r <= swWdata;
        crc_host_pkg::H_DATA: data_r <= swWdata;
        default: ;
      endcase
    end
  end

  // Flags that software or the device interrupt sets and the sequencer clears; a set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_r <= 1'b0;
      finishReq_r <= 1'b0;
      irqFlag_r <= 1'b0;
    end else begin
      if (dataWr) begin
        pending_r <= 1'b1;
      end else if (consume || abortCmd) begin
        pending_r <= 1'b0;
      end
      if (finishCmd) begin
        finishReq_r <= 1'b1;
      end else if (state_r == crc_host_pkg::S_FIN || abortCmd) begin
        finishReq_r <= 1'b0;
      end
      if (devIrq) begin
        irqFlag_r <= 1'b1;
      end else if (irqClear) begin
        irqFlag_r <= 1'b0;
      end
    end
  end

  // Sequencer and device port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= crc_host_pkg::S_IDLE;
      waitNext_r <= crc_host_pkg::S_IDLE;
      devBus_r <= '0;
      idx_r <= 7'h00;
      wait_r <= 7'h00;
      chkEmpty_r <= 1'b0;
      ansWait_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 32'h0000_0000;
    end else begin
      devBus_r.wr <= 1'b0;
      devBus_r.rd <= 1'b0;
      if (abortCmd) begin
        // Dropping enable clears the device FIFO, count and engine
        devBus_r <= '{wr: 1'b1, rd: 1'b0, addr: crc_host_pkg::DEV_CON1, wdata: 16'h0000}; // RULE21
        state_r <= crc_host_pkg::S_IDLE;
      end else begin
        case (state_r)
          crc_host_pkg::S_IDLE: begin
            if (startCmd) begin
              done_r <= 1'b0;
              idx_r <= 7'h00;
              state_r <= crc_host_pkg::S_SETUP;
            end
          end
          crc_host_pkg::S_SETUP: begin
            devBus_r.wr <= 1'b1;
            case (idx_r[2:0])
              3'h0: begin
                devBus_r.addr <= crc_host_pkg::DEV_CON1;
                devBus_r.wdata <= con1Word(1'b0, lsbFirst); // RULE1
              end
              3'h1: begin
                devBus_r.addr <= crc_host_pkg::DEV_CON2;
                devBus_r.wdata <= con2Word(width, poly_length_field); // RULE2 RULE3
              end
              3'h2: begin
                devBus_r.addr <= crc_host_pkg::DEV_TAPL;
                devBus_r.wdata <= taps_r[15:0]; // RULE2
              end
              3'h3: begin
                devBus_r.addr <= crc_host_pkg::DEV_TAPH;
                devBus_r.wdata <= taps_r[31:16];
              end
              3'h4: begin
                devBus_r.addr <= crc_host_pkg::DEV_CON1;
                devBus_r.wdata <= con1Word(1'b1, lsbFirst); // RULE4
              end
              3'h5: begin
                devBus_r.addr <= crc_host_pkg::DEV_RESL;
                devBus_r.wdata <= seed_r[15:0]; // RULE5 RULE15
              end
              default: begin
                devBus_r.addr <= crc_host_pkg::DEV_RESH;
                devBus_r.wdata <= seed_r[31:16];
              end
            endcase
            idx_r <= idx_r + 7'h01;
            if (idx_r[2:0] == crc_host_pkg::SETUP_LAST) begin
              state_r <= crc_host_pkg::S_POLL;
            end
          end
          crc_host_pkg::S_POLL: begin
            if (pending_r || finishReq_r) begin
              devBus_r.rd <= 1'b1;
              devBus_r.addr <= crc_host_pkg::DEV_CON1;
              chkEmpty_r <= !pending_r;
              ansWait_r <= 1'b1;
              state_r <= crc_host_pkg::S_CHK;
            end
          end
          crc_host_pkg::S_CHK: begin
            if (ansWait_r) begin
              // Read data stand only in the cycle after the strobe
              ansWait_r <= 1'b0;
            end else if (!chkEmpty_r) begin
              if (devRdata[crc_host_pkg::CON1_FULL]) begin // RULE6 RULE22
                state_r <= crc_host_pkg::S_POLL;
              end else begin
                devBus_r.wr <= 1'b1;
                devBus_r.addr <= crc_host_pkg::DEV_DATL; // RULE20
                devBus_r.wdata <= data_r[15:0];
                state_r <= crc_host_pkg::S_FEEDH;
              end
            end else if (!devRdata[crc_host_pkg::CON1_EMPTY]) begin // RULE7
              state_r <= crc_host_pkg::S_POLL;
            end else if (width > poly_length_field) begin
              wait_r <= 7'((7'(width) + 7'h01) >> 1); // RULE8
              waitNext_r <= crc_host_pkg::S_FLUSH;
              idx_r <= 7'h00;
              state_r <= crc_host_pkg::S_WAIT;
            end else begin
              idx_r <= 7'h00;
              state_r <= crc_host_pkg::S_FLUSH;
            end
          end
          crc_host_pkg::S_FEEDH: begin
            devBus_r.wr <= 1'b1;
            devBus_r.addr <= crc_host_pkg::DEV_DATH; // RULE20 RULE15
            devBus_r.wdata <= data_r[31:16];
            state_r <= crc_host_pkg::S_POLL;
          end
          crc_host_pkg::S_WAIT: begin
            if (wait_r == 7'h00) begin
              state_r <= waitNext_r;
            end else if (tick) begin
              wait_r <= wait_r - 7'h01;
            end
          end
          crc_host_pkg::S_FLUSH: begin
            idx_r <= idx_r + 7'h01;
            devBus_r.wr <= 1'b1;
            if (width > poly_length_field) begin
              // Width equal to length, then one dummy word pushes the result out
              if (idx_r == 7'h00) begin
                devBus_r.addr <= crc_host_pkg::DEV_CON2;
                devBus_r.wdata <= con2Word(poly_length_field, poly_length_field); // RULE9
              end else if (idx_r == 7'h01) begin
                devBus_r.addr <= crc_host_pkg::DEV_DATL;
                devBus_r.wdata <= 16'h0000; // RULE9
              end else begin
                devBus_r.addr <= crc_host_pkg::DEV_DATH;
                devBus_r.wdata <= 16'h0000;
                wait_r <= 7'(crc_host_pkg::MOVE_WAIT + ((7'(poly_length_field) + 7'h01) >> 1)); // RULE10 RULE19
                waitNext_r <= crc_host_pkg::S_RDL;
                state_r <= crc_host_pkg::S_WAIT;
              end
            end else if (idx_r == 7'h00) begin
              devBus_r.addr <= crc_host_pkg::DEV_CON1;
              devBus_r.wdata <= con1Word(1'b0, lsbFirst); // RULE13 RULE11
            end else if (idx_r <= 7'(dummyWords << 1)) begin
              devBus_r.addr <= idx_r[0] ? crc_host_pkg::DEV_DATL : crc_host_pkg::DEV_DATH; // RULE13
              devBus_r.wdata <= 16'h0000;
            end else begin
              devBus_r.addr <= crc_host_pkg::DEV_CON1;
              devBus_r.wdata <= con1Word(1'b1, lsbFirst); // RULE13
              state_r <= crc_host_pkg::S_IRQ;
            end
          end
          crc_host_pkg::S_IRQ: begin
            if (irqFlag_r) begin // RULE14 RULE11
              state_r <= crc_host_pkg::S_RDL;
            end
          end
          crc_host_pkg::S_RDL: begin
            devBus_r.rd <= 1'b1;
            devBus_r.addr <= crc_host_pkg::DEV_RESL; // RULE12
            state_r <= crc_host_pkg::S_RDH;
          end
          crc_host_pkg::S_RDH: begin
            ansWait_r <= 1'b1;
            devBus_r.rd <= 1'b1;
            devBus_r.addr <= crc_host_pkg::DEV_RESH;
            state_r <= crc_host_pkg::S_FIN;
          end
          crc_host_pkg::S_FIN: begin
            ansWait_r <= 1'b0;
            if (ansWait_r) begin
              result_r[15:0] <= devRdata; // RULE12
            end else begin
              result_r[31:16] <= devRdata; // RULE12
              devBus_r.wr <= 1'b1;
              devBus_r.addr <= crc_host_pkg::DEV_CON2;
              devBus_r.wdata <= con2Word(width, poly_length_field); // RULE12
              done_r <= 1'b1;
              state_r <= crc_host_pkg::S_IDLE;
            end
          end
          default: state_r <= crc_host_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swRdata <= 32'h0000_0000;
    end else if (swRe) begin
      case (swAddr)
        crc_host_pkg::H_CFG: swRdata <= cfg_r;
        crc_host_pkg::H_TAPS: swRdata <= taps_r;
        crc_host_pkg::H_SEED: swRdata <= seed_r;
        crc_host_pkg::H_DATA: swRdata <= data_r;
        crc_host_pkg::H_STATUS: swRdata <= {28'h0000000, irqFlag_r, done_r, pending_r,
                                            state_r != crc_host_pkg::S_IDLE};
        crc_host_pkg::H_RESULT: swRdata <= result_r;
        default: swRdata <= 32'h0000_0000;
      endcase
    end else begin
      swRdata <= 32'h0000_0000;
    end
  end
endmodule

// ==== crc_host_monitor.sv ====
// Assertion checker for the CRC host controller, bound to its top ports.
// Assumes the device register port answers reads one cycle late.
`timescale 1ns/1ps
module crc_host_monitor #(
  parameter int INSTR_CLKS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software port
  input wire logic [3:0] swAddr,
  input wire logic [31:0] swWdata,
  input wire logic swWe,
  input wire logic swRe,
  input wire logic [31:0] swRdata,
  // Device port
  input crc_host_pkg::devBus_t devBus,
  input wire logic [15:0] devRdata,
  input wire logic devIrq
);
  logic [31:0] cfg_r;
  logic wrSeen_r, rdCon1_r, emptySeen_r;
  wire wr = devBus.wr;
  wire [2:0] ad = devBus.addr;
  wire [15:0] wd = devBus.wdata;

  // A disabling write re-arms the check, so a restart must lead with enable too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
      wrSeen_r <= 1'b0;
      rdCon1_r <= 1'b0;
      emptySeen_r <= 1'b0;
    end else begin
      if (swWe && swAddr == crc_host_pkg::H_CFG) cfg_r <= swWdata;
      if (wr) wrSeen_r <= (ad != crc_host_pkg::DEV_CON1) || wd[15];
      rdCon1_r <= devBus.rd && ad == crc_host_pkg::DEV_CON1;
      if (rdCon1_r && devRdata[crc_host_pkg::CON1_EMPTY]) emptySeen_r <= 1'b1;
      else if (wr && ad == crc_host_pkg::DEV_DATL) emptySeen_r <= 1'b0;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_enable_first: assert property (wr && !wrSeen_r |-> ad == crc_host_pkg::DEV_CON1 && wd[15])
    else $error("device written before enable");
  a_taps_after_len: assert property (wr && ad == crc_host_pkg::DEV_TAPL |->
    $past(wr) && $past(ad) == crc_host_pkg::DEV_CON2) else $error("taps before length");
  a_width_field: assert property (wr && ad == crc_host_pkg::DEV_CON2 |-> wd[4:0] == cfg_r[4:0] &&
    (wd[12:8] == cfg_r[12:8] || wd[12:8] == cfg_r[4:0])) else $error("bad width or length");
  a_order_select: assert property (wr && ad == crc_host_pkg::DEV_CON1 && wd[15] |->
    wd[3] == cfg_r[16] && !wd[5]) else $error("bad order or irq select");
  a_seed_after_go: assert property (wr && ad == crc_host_pkg::DEV_RESL |->
    $past(wr) && $past(ad) == crc_host_pkg::DEV_CON1 && $past(wd[4]) ##1 wr && ad == crc_host_pkg::DEV_RESH)
    else $error("seed not after start");
  a_low_then_high: assert property (wr && ad == crc_host_pkg::DEV_DATH |->
    $past(wr) && $past(ad) == crc_host_pkg::DEV_DATL) else $error("high half without low");
  a_feed_not_full: assert property (wr && ad == crc_host_pkg::DEV_DATL && $past(devBus.rd, 2) &&
    $past(ad, 2) == crc_host_pkg::DEV_CON1 |-> !$past(devRdata[7])) else $error("word fed while full");
  a_flush_after_empty: assert property (wr && ad == crc_host_pkg::DEV_CON2 && wd[12:8] != cfg_r[12:8] |->
    emptySeen_r) else $error("flush before empty");
  a_stop_after_empty: assert property (wr && ad == crc_host_pkg::DEV_CON1 && wd[15] && !wd[4] ##1
    wr && ad == crc_host_pkg::DEV_DATL |-> emptySeen_r) else $error("stop before empty");
  a_result_pair: assert property (devBus.rd && ad == crc_host_pkg::DEV_RESL |=>
    devBus.rd && ad == crc_host_pkg::DEV_RESH) else $error("result halves split");
  a_restart_dummy: assert property (wr && ad == crc_host_pkg::DEV_CON1 && wd[15] && !wd[4] |->
    ##[1:200] wr && ad == crc_host_pkg::DEV_CON1 && wd[4]) else $error("shifter not restarted");
endmodule

bind crc_host crc_host_monitor #(.INSTR_CLKS(INSTR_CLKS)) crc_host_monitor_i (.clk(clk), .rst_n(rst_n),
  .swAddr(swAddr), .swWdata(swWdata), .swWe(swWe), .swRe(swRe), .swRdata(swRdata), .devBus(devBus),
  .devRdata(devRdata), .devIrq(devIrq));

// ==== crc_host_pkg.sv ====
// Constants and types shared by the CRC generator host controller.
// Assumes a 16-bit device register port with eight word registers.
package crc_host_pkg;
  // Device register indices
  localparam logic [2:0] DEV_CON1 = 3'h0;
  localparam logic [2:0] DEV_CON2 = 3'h1;
  localparam logic [2:0] DEV_TAPL = 3'h2;
  localparam logic [2:0] DEV_TAPH = 3'h3;
  localparam logic [2:0] DEV_DATL = 3'h4;
  localparam logic [2:0] DEV_DATH = 3'h5;
  localparam logic [2:0] DEV_RESL = 3'h6;
  localparam logic [2:0] DEV_RESH = 3'h7;
  // control_status_low fields
  localparam int CON1_ENABLE = 15;
  localparam int CON1_FULL = 7;
  localparam int CON1_EMPTY = 6;
  localparam int CON1_IRQSEL = 5;
  localparam int CON1_GO = 4;
  localparam int CON1_LSBFIRST = 3;
  // control_width_reg fields
  localparam int CON2_WIDTH_LO = 8;
  localparam int CON2_POLY_LENGTH_FIELD_LO = 0;
  // Host register offsets
  localparam logic [3:0] H_CFG = 4'h0;
  localparam logic [3:0] H_TAPS = 4'h1;
  localparam logic [3:0] H_SEED = 4'h2;
  localparam logic [3:0] H_DATA = 4'h3;
  localparam logic [3:0] H_CMD = 4'h4;
  localparam logic [3:0] H_STATUS = 4'h5;
  localparam logic [3:0] H_RESULT = 4'h6;
  // Host field positions
  localparam int CFG_WIDTH_LO = 8;
  localparam int CFG_LSBFIRST = 16;
  localparam int CMD_START = 0;
  localparam int CMD_FINISH = 1;
  localparam int CMD_ABORT = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_PENDING = 1;
  localparam int ST_DONE = 2;
  localparam int ST_IRQ = 3;
  // Setup writes and the instruction-cycle waits around a flush
  localparam logic [2:0] SETUP_LAST = 3'h6;
  localparam logic [6:0] MOVE_WAIT = 7'h02;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } devBus_t;

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_SETUP = 11'h002,
    S_POLL  = 11'h004,
    S_CHK   = 11'h008,
    S_FEEDH = 11'h010,
    S_WAIT  = 11'h020,
    S_FLUSH = 11'h040,
    S_IRQ   = 11'h080,
    S_RDL   = 11'h100,
    S_RDH   = 11'h200,
    S_FIN   = 11'h400
  } state_t;
endpackage

// ==== crc_host_tb.sv ====
// Self-checking bench for the CRC host controller against a device model.
// Assumes the controller's register map and flush sequence as handed over.
`timescale 1ns/1ps
module crc_host_tb;
  logic clk, rst_n, swWe, swRe, devIrq;
  logic [3:0] swAddr;
  logic [31:0] swWdata, swRdata, rdv;
  logic [15:0] devRdata;
  crc_host_pkg::devBus_t devBus;
  int n_fail, comparisons;

  crc_host #(.INSTR_CLKS(2)) crc_host_i (.clk(clk), .rst_n(rst_n), .swAddr(swAddr), .swWdata(swWdata),
    .swWe(swWe), .swRe(swRe), .swRdata(swRdata), .devBus(devBus), .devRdata(devRdata), .devIrq(devIrq));
  crc_device_model #(.INSTR_CLKS(2)) crc_device_model_i (.clk(clk), .rst_n(rst_n), .devBus(devBus),
    .devRdata(devRdata), .devIrq(devIrq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(logic [31:0] seen, logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    swAddr <= a;
    swWdata <= d;
    swWe <= 1'b1;
    @(posedge clk);
    swWe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [3:0] a, output logic [31:0] v);
    swAddr <= a;
    swRe <= 1'b1;
    @(posedge clk);
    swRe <= 1'b0;
    #1 v = swRdata;
    @(posedge clk);
  endtask

  task automatic pollStatus(int idx, logic val);
    for (int i = 0; i < 3000; i++) begin
      rd(crc_host_pkg::H_STATUS, rdv);
      if (rdv[idx] === val) break;
    end
    check(32'(rdv[idx]), 32'(val));
  endtask

  // Reference shift, one bit at a time; a normal CRC whatever the data order
  function automatic logic [31:0] crcBits(logic [31:0] c, int pl, logic [31:0] d, int n, logic lsb);
    logic fb;
    for (int i = 0; i < n; i++) begin
      fb = c[pl] ^ (lsb ? d[i] : d[n - 1 - i]);
      c = ((c << 1) ^ (fb ? 32'h0000_1021 : 32'h0)) & (32'hffff_ffff >> (31 - pl));
    end
    return c;
  endfunction

  task automatic runCrc(int pl, int w, logic lsb, int nw);
    logic [31:0] expv, d;
    pollStatus(crc_host_pkg::ST_BUSY, 1'b0);
    wr(crc_host_pkg::H_CFG, {15'h0, lsb, 3'h0, 5'(w), 3'h0, 5'(pl)});
    wr(crc_host_pkg::H_TAPS, 32'h0000_1020);
    wr(crc_host_pkg::H_SEED, 32'h0000_ffff);
    wr(crc_host_pkg::H_CMD, 32'h0000_0001);
    expv = 32'h0000_ffff;
    for (int i = 0; i < nw; i++) begin
      d = 32'(32'h9e37_79b9 * (i + 1));
      pollStatus(crc_host_pkg::ST_PENDING, 1'b0);
      wr(crc_host_pkg::H_DATA, d);
      expv = crcBits(expv, pl, d, w + 1, lsb);
    end
    wr(crc_host_pkg::H_CMD, 32'h0000_0002);
    pollStatus(crc_host_pkg::ST_DONE, 1'b1);
    expv = crcBits(expv, pl, 32'h0, w > pl ? pl + 1 : (pl + w + 1) / (w + 1) * (w + 1), 1'b0);
    rd(crc_host_pkg::H_RESULT, rdv);
    check(rdv, expv);
    $display("crc run with length %0d and width %0d done", pl + 1, w + 1);
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    swWe = 1'b0;
    swRe = 1'b0;
    swAddr = '0;
    swWdata = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(crc_host_pkg::H_STATUS, rdv);
    check(rdv, 32'h0);
    rd(4'hf, rdv);
    check(rdv, 32'h0);
    $display("reset and unmapped read test done");
    runCrc(15, 31, 1'b0, 6);
    wr(crc_host_pkg::H_CMD, 32'h0000_0001);
    wr(crc_host_pkg::H_DATA, 32'h1234_5678);
    pollStatus(crc_host_pkg::ST_PENDING, 1'b0);
    wr(crc_host_pkg::H_CMD, 32'h0000_0004);
    pollStatus(crc_host_pkg::ST_BUSY, 1'b0);
    $display("abort test done");
    runCrc(15, 7, 1'b1, 5);
    runCrc(7, 7, 1'b0, 3);
    close_out();
  end
endmodule
